/* hdl/iwd_cfg.svh */
// Constants for the instruction word decoder and timing block.
`ifndef IWD_CFG_SVH
`define IWD_CFG_SVH
`define IWD_WORD_W 14
`define IWD_OSC_PER_CYC 4
`define IWD_FILE_W 7
`define IWD_BIT_W 3
`define IWD_LIT8_W 8
`define IWD_LIT11_W 11
`define IWD_LIT7_W 7
`define IWD_LIT5_W 5
`define IWD_LIT9_W 9
`define IWD_LIT6_W 6
`define IWD_MODE_W 2
`define IWD_DEST_POS 7
`define IWD_NOP_WORD 14'h0000
`define IWD_RETURN_WORD 14'h0008
`define IWD_INTERRUPT_EXIT_WORD 14'h0009
`define IWD_ACCUMULATOR_SUBROUTINE_ENTRY_WORD 14'h000A
`define IWD_BRW_WORD 14'h000B
`define IWD_IND0_ADDR 7'h00
`define IWD_IND1_ADDR 7'h01
`endif

/* hdl/iwd_pkg.sv */
// Types shared by the instruction word decoder modules.
package iwd_pkg;
    typedef enum logic [1:0] {
        IWD_GRP_BYTE = 2'h0,
        IWD_GRP_BIT = 2'h1,
        IWD_GRP_LIT = 2'h2
    } iwd_group_e;
    typedef enum logic [1:0] {
        IWD_Q1 = 2'h0,
        IWD_Q2 = 2'h1,
        IWD_Q3 = 2'h3,
        IWD_Q4 = 2'h2
    } iwd_phase_e;
    typedef struct packed {
        iwd_group_e group;
        logic [6:0] file_addr;
        logic dest_file;
        logic [2:0] bit_num;
        logic [7:0] lit8;
        logic [10:0] lit11;
        logic [6:0] lit7;
        logic [4:0] lit5;
        logic [8:0] lit9;
        logic [5:0] lit6;
        logic ptr_sel;
        logic [1:0] ptr_mode;
        logic two_cycle;
        logic cond_skip;
        logic file_write;
        logic indirect;
    } iwd_fields_s;
endpackage

/* hdl/iwd_dec_if.sv */
// Interface carrying one decoded instruction between the decoder modules.
`timescale 1ns/1ns
interface iwd_dec_if;
    import iwd_pkg::*;
    logic [13:0] word;
    // A net, so the decoder may drive each field by its own assignment.
    wire iwd_fields_s fields;
    modport src (output word, input fields);
    modport dec (input word, output fields);
endinterface

/* hdl/iwd_phase_gen.sv */
// Divides the oscillator clock into four phases of one instruction cycle.
`timescale 1ns/1ns
module iwd_phase_gen
    import iwd_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_reset,
    output iwd_phase_e o_phase,
    output logic o_cycle_end
);
    iwd_phase_e next_phase;

    // Gray walk through the four phases; one count per rising oscillator edge.
    always_comb begin
        case (o_phase)
            IWD_Q1: next_phase = IWD_Q2;
            IWD_Q2: next_phase = IWD_Q3;
            IWD_Q3: next_phase = IWD_Q4;
            IWD_Q4: next_phase = IWD_Q1;
            default: next_phase = IWD_Q1;
        endcase
    end

    // Phase register and end-of-cycle strobe, both registered.
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_phase <= IWD_Q1;
            o_cycle_end <= 1'b0;
        end else begin
            o_phase <= next_phase; // RULE8
            o_cycle_end <= (next_phase == IWD_Q4);
        end
    end
endmodule // iwd_phase_gen

/* hdl/iwd_field_dec.sv */
// Combinational split of a 14-bit instruction word into its fields.
`timescale 1ns/1ns
`include "iwd_cfg.svh"
module iwd_field_dec
    import iwd_pkg::*;
(
    iwd_dec_if.dec bus
);
    wire logic [13:0] w = bus.word;
    wire logic top00 = (w[13:12] == 2'h0);
    // The row below the accumulator store form holds control operations.
    wire logic is_byte00 = top00 && (w[13:7] != 7'h00);
    // Shift and carry arithmetic rows live among the literal codes.
    wire logic is_byte11 = (w[13:12] == 2'h3) &&
        ((w[11:8] == 4'h5) || (w[11:8] == 4'h6) || (w[11:8] == 4'h7) ||
         (w[11:8] == 4'hB) || (w[11:8] == 4'hD));
    wire logic is_byte = is_byte00 || is_byte11;
    // Offset forms carry the pointer select in bit 6, others in bit 2.
    wire logic is_ptr_ofs = (w[13:7] == 7'h62) || (w[13:7] == 7'h7E);
    wire logic is_bit = (w[13:12] == 2'h1);
    wire logic is_accumulator_subroutine_entry = (w == `IWD_ACCUMULATOR_SUBROUTINE_ENTRY_WORD);
    wire logic is_ret = (w == `IWD_RETURN_WORD) || (w == `IWD_INTERRUPT_EXIT_WORD);
    wire logic is_brw = (w == `IWD_BRW_WORD);
    wire logic is_call_absolute_jump = (w[13:12] == 2'h2);
    wire logic is_subroutine_exit_with_literal = (w[13:8] == 6'h34);
    wire logic is_bra = (w[13:9] == 5'h19);
    wire logic is_skipbit = is_bit && w[11];
    wire logic is_cntskip = is_byte00 && ((w[11:8] == 4'hB) ||
                                        (w[11:8] == 4'hF));
    // Byte ops carry file writes from 0x01 up; only the zero-opcode row is left out.
    wire logic byte_op = is_byte && (w[11:8] != 4'h0);
    wire logic movwf = is_byte && (w[11:7] == 5'h01);
    wire logic clrf = is_byte && (w[11:7] == 5'h03);
    wire logic bitset = is_bit && !w[11];
    wire logic names_file = byte_op || movwf || clrf || is_bit;
    wire logic [6:0] f = w[6:0];

    // Classification into the three groups.
    assign bus.fields.group = is_byte ? IWD_GRP_BYTE : // RULE2
                              is_bit ? IWD_GRP_BIT : IWD_GRP_LIT;
    assign bus.fields.file_addr = f; // RULE11
    assign bus.fields.dest_file = w[`IWD_DEST_POS]; // RULE10
    assign bus.fields.bit_num = w[9:7]; // RULE12
    assign bus.fields.lit8 = w[7:0]; // RULE13
    assign bus.fields.lit11 = w[10:0]; // RULE14
    assign bus.fields.lit7 = w[6:0]; // RULE15
    assign bus.fields.lit5 = w[4:0]; // RULE16
    assign bus.fields.lit9 = w[8:0]; // RULE17
    assign bus.fields.lit6 = w[5:0]; // RULE18
    assign bus.fields.ptr_sel = is_ptr_ofs ? w[6] : w[2]; // RULE19
    assign bus.fields.ptr_mode = w[1:0]; // RULE20
    // Fixed two-cycle classes; skips are only conditionally two.
    assign bus.fields.two_cycle = is_accumulator_subroutine_entry || is_call_absolute_jump || // RULE4
                                  is_ret || is_subroutine_exit_with_literal || // RULE5
                                  is_bra || is_brw; // RULE6
    assign bus.fields.cond_skip = is_skipbit || is_cntskip; // RULE6
    // Writes back to the file only when d is 1, or for single-target ops.
    assign bus.fields.file_write = movwf || clrf || bitset ||
                                   (byte_op && w[`IWD_DEST_POS]); // RULE9
    assign bus.fields.indirect = names_file &&
        ((f == `IWD_IND0_ADDR) || (f == `IWD_IND1_ADDR)); // RULE7
endmodule // iwd_field_dec

/* hdl/iwd_core_timing.sv */
// Notes on behaviour
// RULE1: Each instruction is one 14-bit word with opcode and all operands.
// RULE2: Opcodes fall into byte, bit, and literal/control groups.
// RULE3: Instructions take one instruction cycle unless listed otherwise.
// RULE4: Direct and accumulator subroutine entry take two cycles.
// RULE5: Subroutine return, literal return and interrupt exit take two cycles.
// RULE6: Jumps, branches, bit skips and count skips take two cycles; the code gives skips the second cycle only when the skip is true.
// RULE7: Indirect access with pointer into program memory adds one cycle.
// RULE8: One instruction cycle is four oscillator cycles.
// RULE9: File-writing instructions read, modify, then store the register.
// RULE10: Destination bit 0 selects accumulator, 1 selects file register.
// RULE11: File address field is 7 bits, 0x00 to 0x7F.
// RULE12: Bit field of 3 bits picks one bit of the register.
// RULE13: General literal ops use the low 8 bits as immediate.
// RULE14: Call and jump carry 11-bit target in bits 10 to 0.
// RULE15: Program counter high latch load carries 7 bits in 6 to 0.
// RULE16: Bank select load carries a 5-bit immediate.
// RULE17: Relative branch carries 9-bit offset in bits 8 to 0.
// RULE18: Pointer offset ops carry pointer select and 6-bit offset.
// RULE19: Pointer select picks pointer 0 or 1.
// RULE20: Pointer increment ops carry a 2-bit mode in bits 1 to 0.
// RULE21: Flow change or true skip takes two cycles; second is no-op.
`timescale 1ns/1ns
`include "iwd_cfg.svh"
module iwd_core_timing
    import iwd_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [13:0] i_instr_word,
    input wire logic i_skip_true,
    input wire logic i_ptr0_msb,
    input wire logic i_ptr1_msb,
    output logic [13:0] o_exec_word,
    output logic [1:0] o_group,
    output logic [6:0] o_file_addr,
    output logic o_dest_file,
    output logic [2:0] o_bit_num,
    output logic [7:0] o_lit8,
    output logic [10:0] o_lit11,
    output logic [6:0] o_lit7,
    output logic [4:0] o_lit5,
    output logic [8:0] o_lit9,
    output logic [5:0] o_lit6,
    output logic o_ptr_sel,
    output logic [1:0] o_ptr_mode,
    output logic o_fetch,
    output logic o_file_read,
    output logic o_file_write,
    output logic o_acc_write,
    output logic o_flush_nop,
    output logic o_extra_cycle,
    output logic [1:0] o_cycles_used
);
    iwd_phase_e phase;
    logic cycle_end;
    logic [13:0] cur_word;
    logic [1:0] remaining;
    logic flush_pend;
    logic skip_s1;
    logic skip_s2;
    logic msb0_s1;
    logic msb0_s2;
    logic msb1_s1;
    logic msb1_s2;
    logic [1:0] next_remaining;
    logic [1:0] cyc_cnt;

    iwd_dec_if dbus ();

    // Four-phase divider derived from the oscillator.
    iwd_phase_gen u_phase (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .o_phase(phase),
        .o_cycle_end(cycle_end)
    );

    iwd_field_dec u_dec (
        .bus(dbus.dec)
    );

    assign dbus.word = cur_word; // RULE1

    // Skip result and pointer bits come from other logic; synchronise.
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            skip_s1 <= 1'b0;
            skip_s2 <= 1'b0;
            msb0_s1 <= 1'b0;
            msb0_s2 <= 1'b0;
            msb1_s1 <= 1'b0;
            msb1_s2 <= 1'b0;
        end else begin
            skip_s1 <= i_skip_true;
            skip_s2 <= skip_s1;
            msb0_s1 <= i_ptr0_msb;
            msb0_s2 <= msb0_s1;
            msb1_s1 <= i_ptr1_msb;
            msb1_s2 <= msb1_s1;
        end
    end

    // The pointer in use is chosen by the low file address bit.
    wire logic ptr_msb = dbus.fields.file_addr[0] ? msb1_s2 : msb0_s2;
    wire logic extra = dbus.fields.indirect && ptr_msb; // RULE7
    wire logic flow = dbus.fields.two_cycle ||
                      (dbus.fields.cond_skip && skip_s2); // RULE21
    wire logic last_cycle = (remaining == 2'h0);
    wire logic do_fetch = cycle_end && last_cycle;

    // Cycles still owed after the current one: base zero, plus extras.
    always_comb begin
        next_remaining = remaining;
        if (cycle_end) begin
            if (last_cycle) begin
                next_remaining = 2'h0; // RULE3
            end else begin
                next_remaining = remaining - 2'h1;
            end
        end
    end

    // Instruction register and cycle bookkeeping. The extra cycles are
    // decided at Q3 of the first cycle, when skip and pointer inputs are
    // settled; this trades a little latency for stable timing inputs.
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            cur_word <= `IWD_NOP_WORD;
            remaining <= 2'h0;
            flush_pend <= 1'b0;
            cyc_cnt <= 2'h0;
        end else begin
            if (do_fetch) begin
                cur_word <= flush_pend ? `IWD_NOP_WORD : i_instr_word;
                flush_pend <= 1'b0;
                cyc_cnt <= 2'h1;
            end else if (cycle_end) begin
                cyc_cnt <= cyc_cnt + 2'h1;
            end
            if (phase == IWD_Q3 && cyc_cnt == 2'h1 && !flush_pend) begin
                remaining <= {1'b0, extra}; // RULE7
                flush_pend <= flow; // RULE21
            end else begin
                remaining <= next_remaining;
            end
        end
    end

    wire logic rd_phase = (phase == IWD_Q2);
    wire logic wr_phase = (phase == IWD_Q4);
    wire logic is_nop = (cur_word == `IWD_NOP_WORD);

    // Registered outputs; fields are held for the whole instruction.
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_exec_word <= `IWD_NOP_WORD;
            o_group <= 2'h0;
            o_file_addr <= 7'h00;
            o_dest_file <= 1'b0;
            o_bit_num <= 3'h0;
            o_lit8 <= 8'h00;
            o_lit11 <= 11'h000;
            o_lit7 <= 7'h00;
            o_lit5 <= 5'h00;
            o_lit9 <= 9'h000;
            o_lit6 <= 6'h00;
            o_ptr_sel <= 1'b0;
            o_ptr_mode <= 2'h0;
            o_fetch <= 1'b0;
            o_file_read <= 1'b0;
            o_file_write <= 1'b0;
            o_acc_write <= 1'b0;
            o_flush_nop <= 1'b0;
            o_extra_cycle <= 1'b0;
            o_cycles_used <= 2'h0;
        end else begin
            o_exec_word <= cur_word;
            o_group <= dbus.fields.group; // RULE2
            o_file_addr <= dbus.fields.file_addr; // RULE11
            o_dest_file <= dbus.fields.dest_file;
            o_bit_num <= dbus.fields.bit_num; // RULE12
            o_lit8 <= dbus.fields.lit8; // RULE13
            o_lit11 <= dbus.fields.lit11; // RULE14
            o_lit7 <= dbus.fields.lit7; // RULE15
            o_lit5 <= dbus.fields.lit5; // RULE16
            o_lit9 <= dbus.fields.lit9; // RULE17
            o_lit6 <= dbus.fields.lit6; // RULE18
            o_ptr_sel <= dbus.fields.ptr_sel; // RULE19
            o_ptr_mode <= dbus.fields.ptr_mode; // RULE20
            o_fetch <= do_fetch; // RULE8
            // Read always precedes the store, even for write-only ops.
            o_file_read <= rd_phase && dbus.fields.file_write &&
                           last_cycle && !is_nop; // RULE9
            o_file_write <= wr_phase && dbus.fields.file_write &&
                            last_cycle && !is_nop; // RULE9
            o_acc_write <= wr_phase && last_cycle && !is_nop &&
                           dbus.fields.group == IWD_GRP_BYTE &&
                           !dbus.fields.dest_file; // RULE10
            o_flush_nop <= flush_pend;
            o_extra_cycle <= !last_cycle;
            o_cycles_used <= cyc_cnt;
        end
    end

    AST_FOUR_PHASE: assert property (@(posedge i_ref_clk) // RULE8
        disable iff (i_reset) $rose(cycle_end) |-> ##4 cycle_end)
        else $error("Instruction cycle is not four clocks.");

    AST_READ_BEFORE_WRITE: assert property (@(posedge i_ref_clk) // RULE9
        disable iff (i_reset) o_file_write |-> $past(o_file_read, 2))
        else $error("File write without preceding read.");

    AST_FLUSH_NOP: assert property (@(posedge i_ref_clk) // RULE21
        disable iff (i_reset) (do_fetch && flush_pend) |=> is_nop)
        else $error("Flushed cycle did not execute as no-op.");

    AST_NOP_QUIET: assert property (@(posedge i_ref_clk) // RULE21
        disable iff (i_reset) is_nop |=> !o_file_write && !o_acc_write)
        else $error("No-op produced a write.");

    AST_DEST_ACC: assert property (@(posedge i_ref_clk) // RULE10
        disable iff (i_reset) o_acc_write |-> !o_dest_file)
        else $error("Accumulator written with file destination.");

    AST_BIT_FIELD: assert property (@(posedge i_ref_clk) // RULE12
        disable iff (i_reset) o_bit_num == $past(cur_word[9:7]))
        else $error("Bit number field wrong.");

    AST_JUMP_FIELD: assert property (@(posedge i_ref_clk) // RULE14
        disable iff (i_reset) o_lit11 == $past(cur_word[10:0]))
        else $error("Jump target field wrong.");

    AST_BRANCH_FIELD: assert property (@(posedge i_ref_clk) // RULE17
        disable iff (i_reset) o_lit9 == $past(cur_word[8:0]))
        else $error("Branch offset field wrong.");

    AST_EXTRA_BOUND: assert property (@(posedge i_ref_clk) // RULE7
        disable iff (i_reset) !last_cycle |-> ##[1:8] last_cycle)
        else $error("Extra cycle ran too long.");

    // Field and timing checks. The field checks restate the word layout
    // on their own, so a decoder slip shows even in words never tested.
    AST_FETCH_PULSE: assert property (@(posedge i_ref_clk) // RULE3
        disable iff (i_reset) o_fetch |=> !o_fetch [*3])
        else $error("Fetch came sooner than one instruction cycle.");

    AST_EXEC_WORD: assert property (@(posedge i_ref_clk) // RULE1
        disable iff (i_reset) o_exec_word == $past(cur_word))
        else $error("Executing word does not follow the fetched word.");

    AST_FILE_FIELD: assert property (@(posedge i_ref_clk) // RULE11
        disable iff (i_reset) o_file_addr == $past(cur_word[6:0]))
        else $error("File address field wrong.");

    AST_DEST_FIELD: assert property (@(posedge i_ref_clk) // RULE10
        disable iff (i_reset) o_dest_file == $past(cur_word[7]))
        else $error("Destination select field wrong.");

    AST_LIT8_FIELD: assert property (@(posedge i_ref_clk) // RULE13
        disable iff (i_reset) o_lit8 == $past(cur_word[7:0]))
        else $error("Eight-bit literal field wrong.");

    AST_LIT7_FIELD: assert property (@(posedge i_ref_clk) // RULE15
        disable iff (i_reset) o_lit7 == $past(cur_word[6:0]))
        else $error("Seven-bit literal field wrong.");

    AST_LIT5_FIELD: assert property (@(posedge i_ref_clk) // RULE16
        disable iff (i_reset) o_lit5 == $past(cur_word[4:0]))
        else $error("Five-bit literal field wrong.");

    AST_LIT6_FIELD: assert property (@(posedge i_ref_clk) // RULE18
        disable iff (i_reset) o_lit6 == $past(cur_word[5:0]))
        else $error("Six-bit offset field wrong.");

    AST_MODE_FIELD: assert property (@(posedge i_ref_clk) // RULE20
        disable iff (i_reset) o_ptr_mode == $past(cur_word[1:0]))
        else $error("Pointer mode field wrong.");

    AST_GROUP_CODE: assert property (@(posedge i_ref_clk) // RULE2
        disable iff (i_reset) o_group != 2'h3)
        else $error("Group code outside the three groups.");

    AST_FLOW_FLUSH: assert property (@(posedge i_ref_clk) // RULE4
        disable iff (i_reset) (phase == IWD_Q3 && cyc_cnt == 2'h1 &&
        !flush_pend && dbus.fields.two_cycle) |=> flush_pend)
        else $error("Two-cycle instruction did not claim its second cycle.");

    AST_READ_PHASE: assert property (@(posedge i_ref_clk) // RULE9
        disable iff (i_reset) o_file_read |-> $past(phase) == IWD_Q2)
        else $error("File read outside its phase.");

    AST_WRITE_PHASE: assert property (@(posedge i_ref_clk) // RULE9
        disable iff (i_reset) o_file_write |-> $past(phase) == IWD_Q4)
        else $error("File write outside its phase.");

    AST_NOP_NO_READ: assert property (@(posedge i_ref_clk) // RULE21
        disable iff (i_reset) is_nop |=> !o_file_read)
        else $error("No-op produced a file read.");

    AST_ACC_GROUP: assert property (@(posedge i_ref_clk) // RULE10
        disable iff (i_reset) o_acc_write |-> o_group == IWD_GRP_BYTE)
        else $error("Accumulator written by a non-byte instruction.");

    AST_EXTRA_PULSE: assert property (@(posedge i_ref_clk) // RULE7
        disable iff (i_reset) o_extra_cycle |=> !o_extra_cycle)
        else $error("Added cycle marker stood too long.");
endmodule // iwd_core_timing

/* sim/iwd_prog_mem.sv */
// Program memory model that hands instruction words to the decoder.
`timescale 1ns/1ns
module iwd_prog_mem (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_fetch,
    output logic [13:0] o_word
);
    logic [13:0] mem [0:255];
    logic [7:0] pc;

    // Step on after the capture edge, so the word holds while it is taken.
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            pc <= 8'h00;
        end else if (i_fetch) begin
            pc <= pc + 8'h01;
        end
    end

    // Each location is one whole instruction with all its operands.
    assign o_word = mem[pc];
endmodule // iwd_prog_mem

/* sim/tb.sv */
// Self-checking testbench for the instruction word decoder and timing.
`timescale 1ns/1ns
module tb;
    logic i_ref_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_skip_true = 1'b0;
    logic i_ptr0_msb = 1'b0;
    logic i_ptr1_msb = 1'b0;
    logic [13:0] i_instr_word, o_exec_word;
    logic [1:0] o_group, o_ptr_mode;
    logic [6:0] o_file_addr, o_lit7;
    logic [2:0] o_bit_num;
    logic [7:0] o_lit8;
    logic [10:0] o_lit11;
    logic [4:0] o_lit5;
    logic [8:0] o_lit9;
    logic [5:0] o_lit6;
    logic o_dest_file, o_ptr_sel, o_fetch;
    logic o_file_read, o_file_write, o_acc_write;
    logic o_flush_nop, o_extra_cycle;
    logic [1:0] o_cycles_used;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    int last_f = -1;
    int last_gap = 4;
    int rd_cyc = 0;
    int n_wr = 0;
    int n_acc = 0;
    int widx = 0;
    int n_ext = 0;

    iwd_core_timing dut (.*);
    iwd_prog_mem u_mem (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_fetch(o_fetch), .o_word(i_instr_word));

    // Oscillator clock of 20 ns and a count of its rising edges.
    initial begin
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) cyc++;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // A store must trail its read by two clocks, even for write-only ops.
    always @(negedge i_ref_clk) begin
        if (o_file_read === 1'b1) rd_cyc = cyc;
        if (o_file_write === 1'b1) begin
            n_wr++;
            chk(16'(cyc - rd_cyc), 16'h0002);
        end
        if (o_acc_write === 1'b1) n_acc++;
        if (o_extra_cycle === 1'b1) n_ext++;
    end

    // Inputs change only after the previous word has read its conditions.
    task automatic step(input logic [13:0] w, input logic sk,
            input logic [1:0] pm, input int gap, input int kind);
        int k;
        k = 0;
        u_mem.mem[widx] = w;
        widx++;
        i_skip_true = sk;
        {i_ptr1_msb, i_ptr0_msb} = pm;
        do begin
            @(negedge i_ref_clk);
            k++;
        end while (o_fetch !== 1'b1 && k < 20);
        chk(16'(o_flush_nop), 16'(kind == 10));
        if (last_f >= 0) begin
            chk(16'(o_cycles_used), 16'(last_gap / 4));
            chk(16'(cyc - last_f), 16'(last_gap));
        end
        last_f = cyc;
        last_gap = gap;
        @(negedge i_ref_clk);
        chk(16'(o_exec_word), (kind == 10) ? 16'h0 : 16'(w));
        if (kind >= 2 && kind <= 8) begin
            chk(16'(o_group), 16'h0002);
        end
        case (kind)
            0: begin
                chk(16'(o_group), 16'h0000);
                chk(16'(o_file_addr), 16'(w[6:0]));
                chk(16'(o_dest_file), 16'(w[7]));
            end
            1: begin
                chk(16'(o_group), 16'h0001);
                chk(16'(o_file_addr), 16'(w[6:0]));
                chk(16'(o_bit_num), 16'(w[9:7]));
            end
            2: chk(16'(o_lit8), 16'(w[7:0]));
            3: chk(16'(o_lit11), 16'(w[10:0]));
            4: chk(16'(o_lit7), 16'(w[6:0]));
            5: chk(16'(o_lit5), 16'(w[4:0]));
            6: chk(16'(o_lit9), 16'(w[8:0]));
            7: chk(16'(o_lit6), 16'(w[5:0]));
            8: begin
                chk(16'(o_ptr_sel), 16'(w[2]));
                chk(16'(o_ptr_mode), 16'(w[1:0]));
            end
            default: ;
        endcase
        repeat (2) @(negedge i_ref_clk);
    endtask

    task automatic st(input logic [13:0] w, input int kind);
        step(w, 1'b0, 2'h0, 4, kind);
    endtask

    // Byte ops at both ends of the file range, to each destination.
    task automatic t_byte();
        int wr0;
        int acc0;
        wr0 = n_wr;
        acc0 = n_acc;
        st(14'h07D5, 0);
        st(14'h077F, 0);
        st(14'h0780, 0);
        st(14'h00A0, 0);
        st(14'h0000, 2);
        st(14'h0000, 2);
        chk(16'(n_wr - wr0), 16'h0003);
        chk(16'(n_acc - acc0), 16'h0001);
    endtask

    // Bit ops, the 8, 7, 5 and 6-bit literals and pointer fields, each one cycle long.
    task automatic t_bit_lit();
        st(14'h17FF, 1);
        st(14'h1000, 1);
        st(14'h30A5, 2);
        st(14'h31D5, 4);
        st(14'h003A, 5);
        st(14'h316A, 7);
        st(14'h0016, 8);
        st(14'h0011, 8);
    endtask

    // Every flow change; the word after each must run as a no-op.
    task automatic t_flow();
        logic [13:0] w [8] = '{14'h2DA5, 14'h27FF, 14'h33C3, 14'h000A,
            14'h000B, 14'h0008, 14'h0009, 14'h3477};
        int kd [8] = '{3, 3, 6, 9, 9, 9, 9, 2};
        for (int i = 0; i < 8; i++) begin
            st(w[i], kd[i]);
            st(14'h3FFF, 10);
        end
    endtask

    // Skips flush the next word only when their test comes out true.
    task automatic t_skip();
        step(14'h19A0, 1'b1, 2'h0, 4, 1);
        st(14'h3FFF, 10);
        step(14'h1DA0, 1'b0, 2'h0, 4, 1);
        st(14'h3011, 2);
        step(14'h0BA1, 1'b1, 2'h0, 4, 0);
        st(14'h3FFF, 10);
        step(14'h0FA1, 1'b0, 2'h0, 4, 0);
        st(14'h3011, 2);
    endtask

    // Indirect access costs a cycle only via a pointer into program memory.
    task automatic t_ind();
        int e0;
        e0 = n_ext;
        step(14'h0780, 1'b0, 2'h1, 8, 0);
        step(14'h1401, 1'b0, 2'h2, 8, 1);
        step(14'h0781, 1'b0, 2'h1, 4, 0);
        st(14'h0000, 2);
        st(14'h0000, 2);
        chk(16'(n_ext - e0), 16'h0002);
    endtask

    task automatic finish_test();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Reset for 20 clocks, then the scenarios in turn.
    initial begin
        repeat (20) @(negedge i_ref_clk);
        chk(16'(o_exec_word), 16'h0000);
        chk(16'(o_fetch), 16'h0000);
        i_reset = 1'b0;
        t_byte();
        t_bit_lit();
        t_flow();
        t_skip();
        t_ind();
        finish_test();
    end

    // The scenarios need under a thousand clocks; this cuts a hang.
    initial begin
        repeat (3000) @(posedge i_ref_clk);
        n_errors++;
        finish_test();
    end
endmodule // tb
